//--- logic/tsc_pkg.sv
// shared constants and types of the timer status and control block
package tsc_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int COUNT_W = 16;
  localparam int DIV_W = 7;

  // register map, byte addresses on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_SC = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_MOD_HI = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_MOD_LO = 3'h4;

  // status/control field layout
  localparam int BIT_FLAG = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_CPWM = 5;
  localparam int CLKS_HI = 4;
  localparam int CLKS_LO = 3;
  localparam int PS_HI = 2;
  localparam int PS_LO = 0;

  // clock source codes
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_BUS = 2'h1;
  localparam logic [1:0] SRC_FIXED = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  localparam logic [2:0] PS_DIV1 = 3'h0;
  localparam logic [DIV_W-1:0] DIV_ONES = 7'h7F;
  localparam logic [DIV_W-1:0] DIV_ZERO = 7'h00;
  localparam logic [DIV_W-1:0] DIV_STEP = 7'h01;

  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [COUNT_W-1:0] RESET_MOD = 16'h0000;

  typedef enum logic [1:0] {
    CLR_IDLE = 2'b01,
    CLR_ARMED = 2'b10
  } tsc_clear_type;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } tsc_dir_type;
endpackage

//--- logic/tsc_prescaler.sv
// clock source selection, external clock synchroniser and power-of-two prescaler
module tsc_prescaler (
  input wire logic clk, // bus clock
  input wire logic rst, // asynchronous reset, high
  input wire logic clkEn, // freezes all state when low
  input wire logic [1:0] sourceSel, // clock source code
  input wire logic [2:0] prescale, // divide code
  input wire logic extClockPin, // external clock pin, asynchronous
  input wire logic fixedTick, // fixed clock tick, already in bus domain
  input wire logic fixedLoopOn, // loop present and enabled
  output logic tick // one-cycle counter advance
);

  logic extMeta, extSync, extLast;
  logic next_extMeta, next_extSync, next_extLast;
  logic [tsc_pkg::DIV_W-1:0] divCount, next_divCount;
  logic srcTick;

  // mask of low divider bits that must all be ones for a tick
  function automatic logic [tsc_pkg::DIV_W-1:0] divMask(input logic [2:0] code);
    divMask = ~(tsc_pkg::DIV_ONES << code);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_extMeta = extMeta;
    next_extSync = extSync;
    next_extLast = extLast;
    if (clkEn) begin
      next_extMeta = extClockPin;
      next_extSync = extMeta;
      next_extLast = extSync;
    end
  end

  // source select sits before the divider, so every source is divided alike
  always_comb begin
    case (sourceSel)
      tsc_pkg::SRC_NONE: srcTick = 1'b0;
      tsc_pkg::SRC_BUS: srcTick = 1'b1;
      tsc_pkg::SRC_FIXED: srcTick = fixedLoopOn ? fixedTick : 1'b1;
      tsc_pkg::SRC_EXT: srcTick = extSync & ~extLast;
      default: srcTick = 1'b0;
    endcase
  end

  always_comb begin
    next_divCount = divCount;
    if (clkEn && srcTick) begin
      next_divCount = divCount + tsc_pkg::DIV_STEP;
    end
  end

  // prescale is read live, so a new code divides from the next cycle on
  assign tick = clkEn & srcTick & ((divCount & divMask(prescale)) == divMask(prescale));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extMeta <= 1'b0;
      extSync <= 1'b0;
      extLast <= 1'b0;
      divCount <= tsc_pkg::DIV_ZERO;
    end else begin
      extMeta <= next_extMeta;
      extSync <= next_extSync;
      extLast <= next_extLast;
      divCount <= next_divCount;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  no_source_tick_a: assert property (@(posedge clk) disable iff (rst)
    sourceSel == tsc_pkg::SRC_NONE |-> !tick) else $error("tick with no source");
  divide_one_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && sourceSel == tsc_pkg::SRC_BUS && prescale == tsc_pkg::PS_DIV1 |-> tick)
    else $error("divide by one missed a tick");
endmodule

//--- logic/tsc_counter.sv
// sixteen-bit counter with modulo wrap and up/down centre mode
module tsc_counter (
  input wire logic clk, // bus clock
  input wire logic rst, // asynchronous reset, high
  input wire logic clkEn, // freezes all state when low, except for a clearCount clear
  input wire logic tick, // prescaled advance
  input wire logic centerMode, // up/down counting
  input wire logic [15:0] modulo, // modulo value, zero means free running
  input wire logic clearCount, // synchronous clear
  output logic [15:0] count, // counter value
  output logic wrapPulse // period end, one cycle
);

  logic [15:0] next_count, top;
  tsc_pkg::tsc_dir_type dir, next_dir;

  assign top = (modulo == tsc_pkg::COUNT_ZERO) ? tsc_pkg::COUNT_MAX : modulo;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_count = count;
    next_dir = dir;
    wrapPulse = 1'b0;
    if (clearCount) begin
      next_count = tsc_pkg::COUNT_ZERO;
      next_dir = tsc_pkg::DIR_UP;
    end else if (clkEn && tick) begin
      if (!centerMode) begin
        next_dir = tsc_pkg::DIR_UP;
        if (count >= top) begin
          next_count = tsc_pkg::COUNT_ZERO;
          wrapPulse = 1'b1;
        end else begin
          next_count = count + tsc_pkg::COUNT_ONE;
        end
      end else begin
        case (dir)
          tsc_pkg::DIR_UP: begin
            if (count >= top && top == tsc_pkg::COUNT_ONE) begin
              // a top of one has no down phase, so the turn itself is the step back to zero
              next_count = tsc_pkg::COUNT_ZERO;
              wrapPulse = 1'b1;
            end else if (count >= top) begin
              next_dir = tsc_pkg::DIR_DOWN;
              next_count = top - tsc_pkg::COUNT_ONE;
            end else begin
              next_count = count + tsc_pkg::COUNT_ONE;
            end
          end
          tsc_pkg::DIR_DOWN: begin
            if (count <= tsc_pkg::COUNT_ONE) begin
              next_dir = tsc_pkg::DIR_UP;
              next_count = tsc_pkg::COUNT_ZERO;
              wrapPulse = (count == tsc_pkg::COUNT_ONE);
            end else begin
              next_count = count - tsc_pkg::COUNT_ONE;
            end
          end
          default: next_dir = tsc_pkg::DIR_UP;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= tsc_pkg::COUNT_ZERO;
      dir <= tsc_pkg::DIR_UP;
    end else begin
      count <= next_count;
      dir <= next_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wrap_to_zero_a: assert property (@(posedge clk) disable iff (rst)
    wrapPulse |=> count == tsc_pkg::COUNT_ZERO) else $error("wrap did not reach zero");
  free_run_a: assert property (@(posedge clk) disable iff (rst)
    clkEn && tick && !clearCount && !centerMode && modulo == tsc_pkg::COUNT_ZERO &&
    count == tsc_pkg::COUNT_MAX |-> wrapPulse) else $error("free run did not wrap");
endmodule

//--- logic/tsc_timer_status_control.sv
// timer status and control: register port, overflow flag, clearing sequence, counter glue

// Behaviour
// - the overflow flag is set when the counter wraps to zero after the modulo (centre mode: counts down to zero), except while half a modulo write is pending.
// - the overflow flag (bit 7) clears only on a read of the register with the flag set followed by a write of zero to that bit.
// - an overflow between the arming read and the clearing write restarts the sequence, so the flag stays set.
// - writing one to the flag bit leaves it unchanged, and reset clears the flag.
// - with the enable in bit 6 set an interrupt is requested while the flag is one; reset clears the enable.
// - bit 5 selects up counting when zero and up/down centre-aligned counting when one; reset clears it.
// - the clock source field in bits 4 to 3 picks none, bus clock, fixed clock or external source.
// - the external source is synchronised to the bus clock, the fixed clock arrives already synchronised.
// - without an active loop the fixed clock selection behaves like the bus clock.
// - the prescale field divides the selected clock by one for code 000 doubling up to 128 for code 111.
// - the prescaler follows synchronisation and source selection and feeds the counter.
// - a new prescale code divides from the cycle after it is written into the register.
// - in up counting, after reaching the modulo value the counter continues from zero, and a zero modulo runs free.
// - any write to the status/control register resets the counter read latch and the modulo write buffer.
module tsc_timer_status_control (
  input wire logic clk, // bus clock, 25 MHz
  input wire logic rst, // asynchronous reset, high
  input wire logic clkEn, // freezes all state when low
  input wire logic [2:0] busAddr, // register address
  input wire logic [7:0] busWrData, // write data
  input wire logic busWrite, // write strobe
  input wire logic busRead, // read strobe
  output logic [7:0] busRdData, // read data, cycle after the read
  input wire logic extClockPin, // external clock pin
  input wire logic fixedTick, // fixed clock tick in bus domain
  input wire logic fixedLoopOn, // loop present and enabled
  output logic overflowIrq, // overflow interrupt request, level
  output logic centerPwm, // centre-aligned mode for all channels
  output logic [15:0] counterValue // counter value
);

  logic flag, irqEnable, centerSel;
  logic next_flag, next_irqEnable, next_centerSel;
  logic [1:0] clockSource, next_clockSource;
  logic [2:0] prescale, next_prescale;
  tsc_pkg::tsc_clear_type clearState, next_clearState;
  logic [15:0] modulo, next_modulo;
  logic [7:0] modBufHi, modBufLo, next_modBufHi, next_modBufLo;
  logic modGotHi, modGotLo, next_modGotHi, next_modGotLo;
  logic cohLatched, next_cohLatched;
  logic [15:0] cohBuf, next_cohBuf;
  logic [7:0] next_busRdData;
  logic next_overflowIrq;
  logic tick, wrapPulse, clearCount, ovfEvent, modPending;
  logic [15:0] count;
  logic scWrite, scRead, cntRead, cntWrite, modHiWrite, modLoWrite;

  // address decode, used for every register strobe
  function automatic logic hit(input logic strobe, input logic [2:0] addr,
                               input logic [2:0] target);
    hit = strobe && (addr == target);
  endfunction

  assign scWrite = clkEn && hit(busWrite, busAddr, tsc_pkg::ADDR_SC);
  assign scRead = clkEn && hit(busRead, busAddr, tsc_pkg::ADDR_SC);
  assign cntRead = clkEn && (hit(busRead, busAddr, tsc_pkg::ADDR_CNT_HI) ||
                             hit(busRead, busAddr, tsc_pkg::ADDR_CNT_LO));
  assign cntWrite = clkEn && (hit(busWrite, busAddr, tsc_pkg::ADDR_CNT_HI) ||
                              hit(busWrite, busAddr, tsc_pkg::ADDR_CNT_LO));
  assign modHiWrite = clkEn && hit(busWrite, busAddr, tsc_pkg::ADDR_MOD_HI);
  assign modLoWrite = clkEn && hit(busWrite, busAddr, tsc_pkg::ADDR_MOD_LO);
  assign clearCount = cntWrite;

  // a half-written modulo holds overflows back until the other byte arrives
  assign modPending = modGotHi | modGotLo;
  assign ovfEvent = clkEn && wrapPulse && !modPending;

  ////////////////////////////////////////////////////////////////////////////
  tsc_prescaler prescaler_u (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .sourceSel(clockSource),
    .prescale(prescale),
    .extClockPin(extClockPin),
    .fixedTick(fixedTick),
    .fixedLoopOn(fixedLoopOn),
    .tick(tick)
  );

  tsc_counter counter_u (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .tick(tick),
    .centerMode(centerSel),
    .modulo(modulo),
    .clearCount(clearCount),
    .count(count),
    .wrapPulse(wrapPulse)
  );

  assign counterValue = count;

  ////////////////////////////////////////////////////////////////////////////
  // control fields, overflow flag and its clearing sequence
  always_comb begin
    next_irqEnable = irqEnable;
    next_centerSel = centerSel;
    next_clockSource = clockSource;
    next_prescale = prescale;
    next_flag = flag;
    next_clearState = clearState;
    if (scWrite) begin
      next_irqEnable = busWrData[tsc_pkg::BIT_IRQ_EN];
      next_centerSel = busWrData[tsc_pkg::BIT_CPWM];
      next_clockSource = busWrData[tsc_pkg::CLKS_HI:tsc_pkg::CLKS_LO];
      next_prescale = busWrData[tsc_pkg::PS_HI:tsc_pkg::PS_LO];
    end
    case (clearState)
      tsc_pkg::CLR_IDLE: begin
        if (scRead && flag && !ovfEvent) begin
          next_clearState = tsc_pkg::CLR_ARMED;
        end
      end
      tsc_pkg::CLR_ARMED: begin
        if (ovfEvent) begin
          next_clearState = tsc_pkg::CLR_IDLE;
        end else if (scWrite) begin
          next_clearState = tsc_pkg::CLR_IDLE;
          if (!busWrData[tsc_pkg::BIT_FLAG]) begin
            next_flag = 1'b0;
          end
        end
      end
      default: next_clearState = tsc_pkg::CLR_IDLE;
    endcase
    // a one written to the flag is never stored, and a new overflow beats the clear
    if (ovfEvent) begin
      next_flag = 1'b1;
    end
  end

  assign next_overflowIrq = next_flag & next_irqEnable;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
      irqEnable <= 1'b0;
      centerSel <= 1'b0;
      clockSource <= tsc_pkg::SRC_NONE;
      prescale <= tsc_pkg::PS_DIV1;
      clearState <= tsc_pkg::CLR_IDLE;
      overflowIrq <= 1'b0;
      centerPwm <= 1'b0;
    end else begin
      flag <= next_flag;
      irqEnable <= next_irqEnable;
      centerSel <= next_centerSel;
      clockSource <= next_clockSource;
      prescale <= next_prescale;
      clearState <= next_clearState;
      overflowIrq <= next_overflowIrq;
      centerPwm <= next_centerSel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modulo write buffer and counter read coherency latch
  always_comb begin
    next_modulo = modulo;
    next_modBufHi = modBufHi;
    next_modBufLo = modBufLo;
    next_modGotHi = modGotHi;
    next_modGotLo = modGotLo;
    next_cohLatched = cohLatched;
    next_cohBuf = cohBuf;
    if (modHiWrite) begin
      next_modBufHi = busWrData;
      next_modGotHi = 1'b1;
    end
    if (modLoWrite) begin
      next_modBufLo = busWrData;
      next_modGotLo = 1'b1;
    end
    if (next_modGotHi && next_modGotLo) begin
      next_modulo = {next_modBufHi, next_modBufLo};
      next_modGotHi = 1'b0;
      next_modGotLo = 1'b0;
    end
    // the first half read freezes both halves; the next read of either half releases them
    if (cntRead) begin
      if (cohLatched) begin
        next_cohLatched = 1'b0;
      end else begin
        next_cohLatched = 1'b1;
        next_cohBuf = count;
      end
    end
    if (cntWrite) begin
      next_cohLatched = 1'b0;
    end
    if (scWrite) begin
      next_cohLatched = 1'b0;
      next_modGotHi = 1'b0;
      next_modGotLo = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modulo <= tsc_pkg::RESET_MOD;
      modBufHi <= tsc_pkg::RESET_BYTE;
      modBufLo <= tsc_pkg::RESET_BYTE;
      modGotHi <= 1'b0;
      modGotLo <= 1'b0;
      cohLatched <= 1'b0;
      cohBuf <= tsc_pkg::COUNT_ZERO;
    end else begin
      modulo <= next_modulo;
      modBufHi <= next_modBufHi;
      modBufLo <= next_modBufLo;
      modGotHi <= next_modGotHi;
      modGotLo <= next_modGotLo;
      cohLatched <= next_cohLatched;
      cohBuf <= next_cohBuf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data: stands one cycle after the read strobe, zero otherwise
  // a low clock enable holds the register too, so a frozen bus keeps its last answer
  always_comb begin
    next_busRdData = busRdData;
    if (clkEn) begin
      next_busRdData = tsc_pkg::READ_ZERO;
    end
    if (clkEn && busRead) begin
      case (busAddr)
        tsc_pkg::ADDR_SC: next_busRdData = {flag, irqEnable, centerSel, clockSource, prescale};
        tsc_pkg::ADDR_CNT_HI: next_busRdData = cohLatched ? cohBuf[15:8] : count[15:8];
        tsc_pkg::ADDR_CNT_LO: next_busRdData = cohLatched ? cohBuf[7:0] : count[7:0];
        tsc_pkg::ADDR_MOD_HI: next_busRdData = modulo[15:8];
        tsc_pkg::ADDR_MOD_LO: next_busRdData = modulo[7:0];
        default: next_busRdData = tsc_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busRdData <= tsc_pkg::READ_ZERO;
    end else begin
      busRdData <= next_busRdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence armRead;
    scRead && flag && !ovfEvent;
  endsequence

  sequence zeroWrite;
    scWrite && !busWrData[tsc_pkg::BIT_FLAG] && !ovfEvent;
  endsequence

  overflow_sets_flag_a: assert property (@(posedge clk) disable iff (rst)
    ovfEvent |=> flag) else $error("overflow did not set flag");
  clear_sequence_a: assert property (@(posedge clk) disable iff (rst)
    armRead ##1 zeroWrite |=> !flag) else $error("clear sequence failed");
  clear_needs_arm_a: assert property (@(posedge clk) disable iff (rst)
    $fell(flag) |-> $past(clearState == tsc_pkg::CLR_ARMED && scWrite))
    else $error("flag cleared without arming read");
  overflow_restart_a: assert property (@(posedge clk) disable iff (rst)
    clearState == tsc_pkg::CLR_ARMED && ovfEvent ##1 zeroWrite |=> flag)
    else $error("overflow lost in clear sequence");
  write_one_keeps_a: assert property (@(posedge clk) disable iff (rst)
    flag && scWrite && busWrData[tsc_pkg::BIT_FLAG] |=> flag)
    else $error("writing one changed flag");
  irq_level_a: assert property (@(posedge clk) disable iff (rst)
    overflowIrq == (flag && irqEnable)) else $error("irq not flag and enable");
  enable_store_a: assert property (@(posedge clk) disable iff (rst)
    scWrite |=> irqEnable == $past(busWrData[tsc_pkg::BIT_IRQ_EN]) &&
    centerPwm == $past(busWrData[tsc_pkg::BIT_CPWM])) else $error("control bits not stored");
  sc_write_resets_a: assert property (@(posedge clk) disable iff (rst)
    scWrite |=> !cohLatched && !modPending) else $error("latches survive control write");
  read_data_a: assert property (@(posedge clk) disable iff (rst)
    scRead |=> busRdData == $past({flag, irqEnable, centerSel, clockSource, prescale}))
    else $error("control read data wrong");
endmodule

//--- bench/tsc_timer_status_control_tb_top.sv
// self-checking bench of the timer status and control block
module tsc_timer_status_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [2:0] busAddr = 3'h0;
  logic [7:0] busWrData = 8'h00;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic [7:0] busRdData;
  logic extClockPin = 1'b0;
  logic fixedTick = 1'b0;
  logic fixedLoopOn = 1'b0;
  logic overflowIrq;
  logic centerPwm;
  logic [15:0] counterValue;
  logic [7:0] rdVal;
  logic [7:0] cyc = 8'h00;
  logic [15:0] maxV;
  logic [15:0] held;
  int wraps;
  int downs;
  int failCount = 0;
  int nCompared = 0;

  `define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin failCount++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end

  tsc_timer_status_control i_dut (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .busAddr(busAddr),
    .busWrData(busWrData),
    .busWrite(busWrite),
    .busRead(busRead),
    .busRdData(busRdData),
    .extClockPin(extClockPin),
    .fixedTick(fixedTick),
    .fixedLoopOn(fixedLoopOn),
    .overflowIrq(overflowIrq),
    .centerPwm(centerPwm),
    .counterValue(counterValue)
  );

  always #20 clk = ~clk;

  // fixed source ticks every other cycle; external edge every 8 cycles, inside the bus/4 limit
  always @(posedge clk) begin
    cyc <= cyc + 8'h01;
    fixedTick <= cyc[0];
    extClockPin <= cyc[2];
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    busAddr <= a;
    busWrData <= d;
    busWrite <= 1'b1;
    @(posedge clk);
    busWrite <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge clk);
    busRead <= 1'b0;
    #1;
    d = busRdData;
  endtask

  // counts advances over n cycles; one tick of slack for the free-running divider phase
  task automatic rate(input logic [7:0] sc, input int n, input int exp);
    logic [15:0] v0;
    int d;
    wr(tsc_pkg::ADDR_SC, sc);
    wr(tsc_pkg::ADDR_CNT_HI, 8'h00);
    #1;
    v0 = counterValue;
    repeat (n) @(posedge clk);
    #1;
    d = int'(counterValue - v0);
    `CHK((d >= exp - 1) && (d <= exp + 1), 1'b1)
  endtask

  task automatic watch(input int n);
    logic [15:0] prev;
    #1;
    prev = counterValue;
    maxV = 16'h0000;
    wraps = 0;
    downs = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (counterValue > maxV) maxV = counterValue;
      if (prev == 16'h0003 && counterValue == 16'h0000) wraps++;
      if (counterValue != 16'h0000 && counterValue == prev - 16'h0001) downs++;
      prev = counterValue;
    end
  endtask

  task automatic results;
    $display("compared %0d, failed %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(tsc_pkg::ADDR_SC, rdVal);
    `CHK(rdVal, 8'h00)
    `CHK({overflowIrq, centerPwm, counterValue}, 18'h00000)
    wr(3'h7, 8'hFF);
    rd(3'h7, rdVal);
    `CHK(rdVal, 8'h00)
    wr(tsc_pkg::ADDR_SC, 8'h20);
    rd(tsc_pkg::ADDR_SC, rdVal);
    `CHK(rdVal, 8'h20)
    `CHK(centerPwm, 1'b1)
    // sources, then every prescale code on the bus clock
    rate(8'h00, 64, 0);
    rate(8'h08, 64, 64);
    rate(8'h10, 64, 64);
    @(posedge clk);
    fixedLoopOn <= 1'b1;
    rate(8'h10, 64, 32);
    rate(8'h18, 64, 8);
    for (int k = 0; k < 8; k++) begin
      rate(8'h08 | k[7:0], 256, 256 >> k);
    end
    // modulo 3: period of four bus cycles
    wr(tsc_pkg::ADDR_MOD_HI, 8'h00);
    wr(tsc_pkg::ADDR_MOD_LO, 8'h03);
    wr(tsc_pkg::ADDR_SC, 8'h48);
    wr(tsc_pkg::ADDR_CNT_LO, 8'h00);
    watch(16);
    `CHK(maxV, 16'h0003)
    `CHK(wraps >= 3, 1'b1)
    `CHK(overflowIrq, 1'b1)
    rd(tsc_pkg::ADDR_SC, rdVal);
    `CHK(rdVal, 8'hC8)
    // arm, let overflows land, so the zero write that stops the counter leaves the flag set
    repeat (8) @(posedge clk);
    wr(tsc_pkg::ADDR_SC, 8'h40);
    rd(tsc_pkg::ADDR_SC, rdVal);
    `CHK(rdVal, 8'hC0)
    wr(tsc_pkg::ADDR_SC, 8'hC0);
    rd(tsc_pkg::ADDR_SC, rdVal);
    `CHK(rdVal, 8'hC0)
    wr(tsc_pkg::ADDR_SC, 8'h80);
    rd(tsc_pkg::ADDR_SC, rdVal);
    `CHK(rdVal, 8'h80)
    `CHK(overflowIrq, 1'b0)
    wr(tsc_pkg::ADDR_SC, 8'hC0);
    #1;
    `CHK(overflowIrq, 1'b1)
    // a zero write without a prior arming read must not clear
    wr(tsc_pkg::ADDR_SC, 8'h40);
    rd(tsc_pkg::ADDR_SC, rdVal);
    `CHK(rdVal, 8'hC0)
    wr(tsc_pkg::ADDR_SC, 8'h40);
    #1;
    `CHK(overflowIrq, 1'b0)
    rd(tsc_pkg::ADDR_SC, rdVal);
    `CHK(rdVal, 8'h40)
    // centre mode: up to the modulo, then back down
    wr(tsc_pkg::ADDR_SC, 8'h28);
    watch(16);
    `CHK(maxV, 16'h0003)
    `CHK(downs >= 2, 1'b1)
    // a control write drops a half-written modulo, so a lone low byte loads nothing
    wr(tsc_pkg::ADDR_MOD_HI, 8'h12);
    wr(tsc_pkg::ADDR_SC, 8'h00);
    wr(tsc_pkg::ADDR_MOD_LO, 8'h34);
    rd(tsc_pkg::ADDR_MOD_HI, rdVal);
    `CHK(rdVal, 8'h00)
    wr(tsc_pkg::ADDR_MOD_HI, 8'h00);
    rd(tsc_pkg::ADDR_MOD_LO, rdVal);
    `CHK(rdVal, 8'h34)
    // a control write between the two counter halves releases the read latch
    wr(tsc_pkg::ADDR_SC, 8'h08);
    wr(tsc_pkg::ADDR_CNT_LO, 8'h00);
    rd(tsc_pkg::ADDR_CNT_HI, rdVal);
    `CHK(rdVal, 8'h00)
    wr(tsc_pkg::ADDR_SC, 8'h08);
    rd(tsc_pkg::ADDR_CNT_LO, rdVal);
    `CHK(rdVal, 8'h05)
    // clock enable low freezes the divider and the counter
    @(posedge clk);
    clkEn <= 1'b0;
    @(posedge clk);
    #1;
    held = counterValue;
    repeat (8) @(posedge clk);
    #1;
    `CHK(counterValue, held)
    @(posedge clk);
    clkEn <= 1'b1;
    results();
  end

  // the whole sequence needs about 2540 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    results();
  end
endmodule
